// >>> design/standby_mode_sequencer.sv
// Standby mode sequencer: software and hardware standby entry and exit
// How it works
// - Halt with select bit set enters software standby
// - Software standby stops processor, peripherals, oscillator
// - Standby keeps state except serial, pulse-width units
// - Only unmaskable, three interrupts, init, standby pins wake
// - Interrupt wake waits settling count, then exception
// - Disabled or masked interrupt lines never wake
// - Init pin low restarts clocks; reset on rise
// - Settle code gives 8192..262144, reserved, 16 states
// - Edge select: 0 falling, 1 rising
// - Standby pin low forces hardware standby always
// - Hardware standby resets all, ports float
// - Standby rise with init low enters reset
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "standby_map.svh"
module standby_mode_sequencer (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic halt_i,
  input wire logic chip_init_pin_n_i,
  input wire logic hw_standby_pin_n_i,
  input wire standby_pkg::wake_s wake_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output standby_pkg::ctl_s ctl_o,
  output logic [2:0] mode_o
);
  import standby_pkg::*;

  mode_e state_q;
  logic [7:0] standby_ctrl_q;
  logic [7:0] sys_ctrl_q;
  logic [7:0] rdata_q;
  logic wake_q;
  logic nmi_edge;
  logic irq_wake;
  logic settle_start;
  logic settle_done;
  logic standby_select;
  logic [2:0] settle_sel;

  assign standby_select = standby_ctrl_q[`SSEL_BIT];
  assign settle_sel = standby_ctrl_q[`SETTLE_CODE_LSB+:3];

  edge_detect u_nmi_edge (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .pin_i(wake_i.nmi),
    .rise_sel_i(sys_ctrl_q[`EDGE_BIT]),
    .edge_o(nmi_edge)
  );

  // Low-level interrupt lines wake only when enabled and unmasked
  assign irq_wake = |(~wake_i.irq & wake_i.irq_en & ~wake_i.irq_mask);

  assign settle_start = (state_q == ST_SW_STANDBY) && hw_standby_pin_n_i &&
                        chip_init_pin_n_i && (nmi_edge || irq_wake);

  settle_counter u_settle (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .start_i(settle_start),
    .sel_i(settle_sel),
    .done_o(settle_done)
  );

  // Mode sequencing
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_RUN;
    end else if (!hw_standby_pin_n_i) begin
      state_q <= ST_HW_STANDBY;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (!chip_init_pin_n_i)
            state_q <= ST_RESET_HOLD;
          else if (halt_i && standby_select)
            state_q <= ST_SW_STANDBY;
        end
        ST_SW_STANDBY: begin
          if (!chip_init_pin_n_i)
            state_q <= ST_RESET_HOLD;
          else if (settle_start)
            state_q <= ST_SETTLE;
        end
        ST_SETTLE: begin
          if (!chip_init_pin_n_i)
            state_q <= ST_RESET_HOLD;
          else if (settle_done)
            state_q <= ST_RUN;
        end
        ST_RESET_HOLD: begin
          if (chip_init_pin_n_i)
            state_q <= ST_RUN;
        end
        ST_HW_STANDBY: begin
          state_q <= ST_RESET_HOLD;
        end
      endcase
    end
  end

  // Interrupt start pulse after a settled wake
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      wake_q <= 1'b0;
    else
      wake_q <= (state_q == ST_SETTLE) && settle_done &&
                hw_standby_pin_n_i && chip_init_pin_n_i;
  end

  // Control registers; hardware standby clears them like a reset
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      standby_ctrl_q <= `STANDBY_CTRL_RST;
      sys_ctrl_q <= `SYS_CTRL_RST;
    end else if (state_q == ST_HW_STANDBY) begin
      standby_ctrl_q <= `STANDBY_CTRL_RST;
      sys_ctrl_q <= `SYS_CTRL_RST;
    end else if (wr_i) begin
      if (addr_i == `STANDBY_CTRL_OFS)
        standby_ctrl_q <= {wdata_i[7:4], 4'h0};
      else if (addr_i == `SYS_CTRL_OFS)
        sys_ctrl_q <= {5'h00, wdata_i[2], 1'b0, wdata_i[0]};
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        `STANDBY_CTRL_OFS: rdata_q <= standby_ctrl_q;
        `SYS_CTRL_OFS: rdata_q <= sys_ctrl_q;
        `STATUS_OFS: rdata_q <= {5'h00, state_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o = rdata_q;
  assign mode_o = state_q;

  // Clock, reset and port controls per mode
  always_comb begin
    ctl_o = '0;
    ctl_o.int_start = wake_q;
    ctl_o.reset_start = (state_q == ST_RESET_HOLD) && chip_init_pin_n_i;
    unique case (state_q)
      ST_RUN: begin
        ctl_o.cpu_clk_en = 1'b1;
        ctl_o.periph_clk_en = 1'b1;
        ctl_o.osc_en = 1'b1;
      end
      ST_SW_STANDBY: begin
        ctl_o.periph_partial_reset = 1'b1;
      end
      ST_SETTLE: begin
        ctl_o.osc_en = 1'b1;
        ctl_o.periph_partial_reset = 1'b1;
      end
      ST_RESET_HOLD: begin
        ctl_o.cpu_clk_en = 1'b1;
        ctl_o.periph_clk_en = 1'b1;
        ctl_o.osc_en = 1'b1;
        ctl_o.chip_reset = 1'b1;
      end
      ST_HW_STANDBY: begin
        ctl_o.chip_reset = 1'b1;
        ctl_o.ports_hiz = 1'b1;
      end
    endcase
  end

endmodule : standby_mode_sequencer

// >>> design/standby_map.svh
// Constants for the standby mode sequencer: field positions, reset values, counts
`ifndef STANDBY_MAP_SVH
`define STANDBY_MAP_SVH

// Register offsets on the plain register port
`define STANDBY_CTRL_OFS 4'h0
`define SYS_CTRL_OFS 4'h1
`define STATUS_OFS 4'h2

// Standby control register fields
`define SSEL_BIT 7
`define SETTLE_CODE_LSB 4
`define STANDBY_CTRL_RST 8'h00

// System control register fields
`define EDGE_BIT 2
`define RAM_EN_BIT 0
`define SYS_CTRL_RST 8'h01

// Settle time codes
`define SETTLE_CODE_RSVD 3'h6
`define SETTLE_CODE_SHORT 3'h7
`define SETTLE_BASE_LOG2 13
`define SETTLE_SHORT 19'h00010

`endif

// >>> design/standby_pkg.sv
// Types shared by the standby mode sequencer
package standby_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SW_STANDBY,
    ST_SETTLE,
    ST_RESET_HOLD,
    ST_HW_STANDBY
  } mode_e;

  // Wake-up request lines from pins and interrupt controller
  typedef struct packed {
    logic nmi;
    logic [2:0] irq;
    logic [2:0] irq_en;
    logic [2:0] irq_mask;
  } wake_s;

  // Clock and reset controls to the rest of the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic chip_reset;
    logic periph_partial_reset;
    logic ports_hiz;
    logic int_start;
    logic reset_start;
  } ctl_s;

endpackage : standby_pkg

// >>> design/settle_counter.sv
// Oscillator settling counter with selectable terminal count
`timescale 1ns/100ps
`include "standby_map.svh"
module settle_counter (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [2:0] sel_i,
  output logic done_o
);

  logic [18:0] cnt_q;
  logic run_q;
  logic [18:0] term;

  // Terminal count per code, 16 for the short code
  function automatic logic [18:0] settle_count(input logic [2:0] s);
    if (s == `SETTLE_CODE_SHORT)
      settle_count = `SETTLE_SHORT;
    else
      settle_count = 19'h00001 << (`SETTLE_BASE_LOG2 + s);
  endfunction : settle_count

  assign term = settle_count(sel_i);

  // Count clock states after oscillator restart
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 19'h00000;
      run_q <= 1'b0;
    end else if (start_i) begin
      cnt_q <= 19'h00000;
      run_q <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q + 19'h00001;
      if (cnt_q + 19'h00001 == term)
        run_q <= 1'b0;
    end
  end

  assign done_o = run_q && (cnt_q + 19'h00001 == term);

endmodule : settle_counter

// >>> design/edge_detect.sv
// Selectable edge detector for the unmaskable interrupt pin
`timescale 1ns/100ps
module edge_detect (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic pin_i,
  input wire logic rise_sel_i,
  output logic edge_o
);

  logic prev_q;

  // Previous pin level; resets to the idle high level, so no false edge
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      prev_q <= 1'b1;
    else
      prev_q <= pin_i;
  end

  assign edge_o = rise_sel_i ? (pin_i && !prev_q) : (!pin_i && prev_q);

endmodule : edge_detect

// >>> test/standby_far.sv
// Far-side model driving the standby, init and wake pins
`timescale 1ns/100ps
module standby_far (
  input wire logic ref_clk_i,
  output logic init_n_o,
  output logic standby_n_o,
  output standby_pkg::wake_s wake_o
);
  import standby_pkg::*;
  // Idle pins: init and standby high, irq lines high, nmi high
  initial begin
    init_n_o = 1'b1;
    standby_n_o = 1'b1;
    wake_o = {1'b1, 3'h7, 3'h0, 3'h0};
  end
  // Change all pins just after a rising edge
  task automatic drive(input logic i_n, input logic s_n, input wake_s w);
    @(posedge ref_clk_i);
    init_n_o <= i_n;
    standby_n_o <= s_n;
    wake_o <= w;
  endtask : drive
  // Init goes low one cycle before standby
  task automatic hw_in();
    drive(1'b0, 1'b1, wake_o);
    drive(1'b0, 1'b0, wake_o);
  endtask : hw_in
endmodule : standby_far

// >>> test/standby_properties.sv
// Assertions on the standby sequencer ports
`timescale 1ns/100ps
module standby_properties (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic halt_i,
  input wire logic chip_init_pin_n_i,
  input wire logic hw_standby_pin_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire standby_pkg::ctl_s ctl_o,
  input wire logic [2:0] mode_o
);
  import standby_pkg::*;
  logic [7:0] sb_q;
  logic [19:0] n_q;
  wire pins = chip_init_pin_n_i & hw_standby_pin_n_i;
  wire [2:0] c = sb_q[6:4];
  wire [19:0] want = (c == 3'h7) ? 20'h10 : (20'h2000 << c);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // Shadow control register and count of settle cycles
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sb_q <= 8'h00;
      n_q <= 20'h0;
    end else begin
      if (mode_o == 3'h4) sb_q <= 8'h00;
      else if (wr_i && addr_i == 4'h0) sb_q <= wdata_i;
      if (mode_o == 3'h2) n_q <= n_q + 20'h1;
      else if (mode_o == 3'h1) n_q <= 20'h0;
    end
  end
  property p_halt;
    halt_i && mode_o == 3'h0 && pins |=> mode_o == {2'h0, sb_q[7]};
  endproperty
  a_halt: assert property (p_halt) else $error("halt entry");
  property p_off;
    mode_o == 3'h1 |-> !(ctl_o.cpu_clk_en | ctl_o.periph_clk_en | ctl_o.osc_en);
  endproperty
  a_off: assert property (p_off) else $error("clocks run");
  property p_cnt;
    mode_o == 3'h2 ##1 mode_o == 3'h0 |-> n_q == want;
  endproperty
  a_cnt: assert property (p_cnt) else $error("settle count");
  property p_ints;
    mode_o == 3'h2 ##1 mode_o == 3'h0 |-> ctl_o.int_start;
  endproperty
  a_ints: assert property (p_ints) else $error("no int start");
  property p_hw;
    !hw_standby_pin_n_i |=> mode_o == 3'h4;
  endproperty
  a_hw: assert property (p_hw) else $error("no hw standby");
  property p_hwst;
    mode_o == 3'h4 |-> ctl_o.chip_reset && ctl_o.ports_hiz && !ctl_o.osc_en;
  endproperty
  a_hwst: assert property (p_hwst) else $error("hw standby state");
  property p_rise;
    mode_o == 3'h4 && pins == 1'b0 && hw_standby_pin_n_i
      |-> ##[1:2] mode_o == 3'h3 && ctl_o.osc_en;
  endproperty
  a_rise: assert property (p_rise) else $error("hw exit");
  property p_init;
    mode_o == 3'h1 && !chip_init_pin_n_i && hw_standby_pin_n_i
      |=> mode_o == 3'h3 && ctl_o.osc_en;
  endproperty
  a_init: assert property (p_init) else $error("init exit");
endmodule : standby_properties

// >>> test/standby_mode_sequencer_tb.sv
// Testbench for the standby mode sequencer
`timescale 1ns/100ps
module standby_mode_sequencer_tb;
  import standby_pkg::*;
  logic ref_clk_i, resetn_i, halt_i, wr_i, rd_i, init_n, standby_n;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata, r;
  logic [2:0] mode;
  wake_s wake;
  ctl_s ctl;
  int errors = 0;
  int n_tests = 0;
  int n;
  localparam wake_s idle = {1'b1, 3'h7, 3'h0, 3'h0};
  standby_mode_sequencer i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .halt_i(halt_i), .chip_init_pin_n_i(init_n),
    .hw_standby_pin_n_i(standby_n),
    .wake_i(wake), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata), .ctl_o(ctl), .mode_o(mode));
  standby_far i_far (.ref_clk_i(ref_clk_i), .init_n_o(init_n),
    .standby_n_o(standby_n), .wake_o(wake));
  // Clock, 10 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data are taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    r = rdata;
  endtask : rd
  task automatic halt();
    @(posedge ref_clk_i);
    halt_i <= 1'b1;
    @(posedge ref_clk_i);
    halt_i <= 1'b0;
  endtask : halt
  // Wait up to lim cycles for mode m, then compare
  task automatic go(input logic [2:0] m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(20'(mode), 20'(m));
  endtask : go
  task automatic t_regs();
    // Halt with the select bit clear is plain sleep, mode stays run
    halt();
    repeat (2) @(negedge ref_clk_i);
    chk(20'(mode), 20'h0);
    rd(4'h1);
    chk(20'(r), 20'h1);
    wr(4'h5, 8'hff);
    rd(4'h5);
    chk(20'(r), 20'h0);
    wr(4'h0, 8'hf0);
    rd(4'h0);
    chk(20'(r), 20'hf0);
  endtask : t_regs
  task automatic t_irq();
    // No USB crystal clock in this bench, so nothing to park
    halt();
    go(3'h1, 2);
    chk(20'(ctl.cpu_clk_en | ctl.osc_en), 20'h0);
    chk(20'(ctl.periph_partial_reset), 20'h1);
    rd(4'h2);
    chk(20'(r), 20'h1);
    i_far.drive(1'b1, 1'b1, {1'b1, 3'h6, 3'h0, 3'h0});
    i_far.drive(1'b1, 1'b1, {1'b1, 3'h6, 3'h1, 3'h1});
    repeat (3) @(negedge ref_clk_i);
    chk(20'(mode), 20'h1);
    i_far.drive(1'b1, 1'b1, {1'b1, 3'h6, 3'h1, 3'h0});
    go(3'h2, 4);
    go(3'h0, 40);
    chk(20'(n), 20'h10);
    chk(20'(ctl.int_start), 20'h1);
    i_far.drive(1'b1, 1'b1, idle);
  endtask : t_irq
  task automatic t_nmi();
    wr(4'h1, 8'h05);
    // Bench clock stands for an external source: no 8 ms floor
    wr(4'h0, 8'h80);
    halt();
    i_far.drive(1'b1, 1'b1, {1'b0, 3'h7, 3'h0, 3'h0});
    repeat (3) @(negedge ref_clk_i);
    chk(20'(mode), 20'h1);
    i_far.drive(1'b1, 1'b1, idle);
    go(3'h2, 4);
    go(3'h0, 9000);
    chk(20'(n), 20'h2000);
  endtask : t_nmi
  task automatic t_init();
    wr(4'h0, 8'hf0);
    halt();
    i_far.drive(1'b0, 1'b1, idle);
    go(3'h3, 3);
    chk(20'(ctl.osc_en), 20'h1);
    repeat (20) @(posedge ref_clk_i);
    i_far.drive(1'b1, 1'b1, idle);
    @(negedge ref_clk_i);
    chk(20'(ctl.reset_start), 20'h1);
    go(3'h0, 4);
  endtask : t_init
  task automatic t_hw();
    wr(4'h1, 8'h04);
    wr(4'h0, 8'hf0);
    halt();
    go(3'h1, 2);
    i_far.hw_in();
    go(3'h4, 3);
    chk(20'(ctl.ports_hiz), 20'h1);
    i_far.drive(1'b0, 1'b1, idle);
    go(3'h3, 3);
    repeat (20) @(posedge ref_clk_i);
    i_far.drive(1'b1, 1'b1, idle);
    go(3'h0, 4);
  endtask : t_hw
  task automatic end_of_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // Watchdog well beyond the longest settle wait
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    errors++;
    end_of_test();
  end
  // Reset for four cycles, then the scenarios
  initial begin
    {resetn_i, halt_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_irq();
    t_nmi();
    t_init();
    t_hw();
    end_of_test();
  end
endmodule : standby_mode_sequencer_tb
bind standby_mode_sequencer standby_properties i_chk (.ref_clk_i, .resetn_i,
  .halt_i, .chip_init_pin_n_i, .hw_standby_pin_n_i, .addr_i, .wdata_i,
  .wr_i, .ctl_o, .mode_o);
